// ===== tsrf_pkg.sv
package tsrf_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TEMPO  = 8'h04;
	localparam logic [7:0] OFS_BEATS  = 8'h08;
	localparam logic [7:0] OFS_PULSE  = 8'h0C;
	localparam logic [7:0] OFS_SMOOTH = 8'h10;
	localparam logic [7:0] OFS_FMIN   = 8'h14;
	localparam logic [7:0] OFS_FMAX   = 8'h18;
	localparam logic [7:0] OFS_RESON  = 8'h1C;
	localparam logic [7:0] OFS_LPHASE = 8'h20;
	localparam logic [7:0] OFS_RPHASE = 8'h24;
	localparam logic [7:0] OFS_WET    = 8'h28;
	localparam logic [7:0] OFS_GAIN   = 8'h2C;
	localparam logic [7:0] OFS_METER  = 8'h30;
	localparam logic [7:0] OFS_PHASE  = 8'h34;
	// Field positions
	localparam int CTRL_WAVE_LSB = 2;
	localparam int CTRL_SYS_BIT  = 5;
	localparam int GAIN_OFF_BIT  = 8;
	// Reset values
	localparam logic [5:0]  RST_CTRL  = 6'h00;
	localparam logic [7:0]  RST_TEMPO = 8'h78;
	localparam logic [9:0]  RST_BEATS = 10'h018;
	localparam logic [6:0]  RST_PULSE = 7'h32;
	localparam logic [13:0] RST_FMIN  = 14'h0008;
	localparam logic [13:0] RST_FMAX  = 14'h20B4;
	localparam logic [6:0]  RST_WET   = 7'h64;
	// Write limits
	localparam logic [31:0] FREQ_LO  = 32'h0000_0008;
	localparam logic [31:0] FREQ_HI  = 32'h0000_20B4;
	localparam logic [31:0] BPM_LO   = 32'h0000_0001;
	localparam logic [31:0] BPM_HI   = 32'h0000_00FF;
	localparam logic [31:0] BEATS_HI = 32'h0000_0300;
	localparam logic [31:0] PCT_HI   = 32'h0000_0064;
	localparam logic [31:0] RESON_HI = 32'h0000_0032;
	localparam logic [31:0] PHASE_HI = 32'h0000_0E10;
	localparam logic signed [7:0] GAIN_LO = 8'shB1;
	localparam logic signed [7:0] GAIN_HI = 8'sh18;
	localparam logic [2:0]  SIZE_WORD = 3'h2;
	// Arithmetic scales; INC_K and FK_Q8 are tied to the audio sample rate
	localparam int SAMPLE_HZ = 32'h0000_BB80;
	localparam logic [15:0] INC_K = 16'((64'h1 << 32) * 64'h18
		/ (64'h3C * 64'(SAMPLE_HZ)));
	localparam logic [31:0] PH_K  = 32'((64'h1 << 32) / 64'hE10);
	localparam logic [31:0] FK_Q8 = 32'(64'h6487F * 64'h100
		/ 64'(SAMPLE_HZ));
	localparam logic [15:0] PCT_K = 16'h028F;
	localparam logic [16:0] F_MAX = 17'h0FFFF;
	typedef enum logic [1:0] {
		RESP_LP = 2'h0, RESP_HP = 2'h1, RESP_BP = 2'h2, RESP_NOTCH = 2'h3
	} tsrf_resp_t;
	typedef enum logic [2:0] {
		WAVE_SINE = 3'h0, WAVE_SAWUP = 3'h1, WAVE_SAWDN = 3'h2,
		WAVE_PULSE = 3'h3, WAVE_TRI = 3'h4
	} tsrf_wave_t;
	typedef enum logic [1:0] {DIV_LOAD = 2'b01, DIV_RUN = 2'b10} tsrf_div_t;

	function automatic logic [31:0] clampu(input logic [31:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	function automatic logic [15:0] pct_q(input logic [6:0] p);
		return 16'(17'(p) * 17'(PCT_K));
	endfunction
	// Linear Q16 value of 2^(db/6), close to the dB scale
	function automatic logic [23:0] db_lin(input logic signed [7:0] db);
		logic signed [7:0] q;
		logic [2:0]        r;
		logic [23:0]       m;
		q = (db >= 0) ? db / 8'sh06 : -((8'sh05 - db) / 8'sh06);
		r = 3'(db - q * 8'sh06);
		case (r)
			3'h1: m = 24'h011F5A;
			3'h2: m = 24'h01428A;
			3'h3: m = 24'h016A0A;
			3'h4: m = 24'h019660;
			3'h5: m = 24'h01C824;
			default: m = 24'h010000;
		endcase
		return (q >= 0) ? m << 5'(q) : m >> 5'(-q);
	endfunction
	// Piecewise-linear log2, Q4.8
	function automatic logic [11:0] log2q(input logic [13:0] f);
		logic [3:0]  e;
		logic [13:0] n;
		e = 4'h0;
		for (int i = 0; i < 14; i++) if (f[i]) e = 4'(i);
		n = f << (4'hD - e);
		return {e, n[12:5]};
	endfunction
	function automatic logic signed [24:0] mixq(
		input logic signed [24:0] a, b, input logic [15:0] s);
		return 25'(a + 25'(((42'(b) - 42'(a))
			* 42'($signed({1'b0, s}))) >>> 16));
	endfunction
	function automatic logic [13:0] fsweep(input logic [15:0] uu,
		input logic [13:0] fa, fb);
		logic signed [12:0] dl;
		logic [11:0]        l;
		logic [21:0]        w;
		dl = $signed({1'b0, log2q(fb)}) - $signed({1'b0, log2q(fa)});
		l = 12'(log2q(fa) + 12'((30'(dl) * 30'($signed({1'b0, uu})))
			>>> 16));
		w = 22'({1'b1, l[7:0]}) << l[11:8];
		return 14'(w >> 8);
	endfunction
	function automatic logic [15:0] wave(input tsrf_wave_t ws,
		input logic [15:0] p, input logic [6:0] pw, sm);
		logic [15:0] trw, sine, pul, sq;
		logic [29:0] h2;
		trw = p[15] ? ~{p[14:0], 1'b0} : {p[14:0], 1'b0};
		h2 = 30'(p[14:0]) * 30'(15'h7FFF - p[14:0]);
		sine = p[15] ? 16'h8000 - h2[28:13] : 16'h8000 + h2[28:13];
		// width sets high share of period
		pul = (p < pct_q(pw)) ? 16'hFFFF : 16'h0000;
		sq = pct_q(sm);
		case (ws)
			WAVE_SAWUP: return 16'(mixq(25'(p), 25'(trw), sq));
			WAVE_SAWDN: return 16'(mixq(25'(~p), 25'(trw), sq));
			WAVE_PULSE: return 16'(mixq(25'(pul), 25'(sine), sq));
			WAVE_TRI:   return trw;
			default:    return sine;
		endcase
	endfunction
	function automatic logic [71:0] svf(input logic signed [23:0] x, lp,
		bp, input logic [16:0] f, input logic [17:0] q,
		input tsrf_resp_t rs);
		logic signed [23:0] a, h, b, yy;
		a = lp + 24'((42'(bp) * $signed({25'h0, f})) >>> 16);
		// damping sets peak and notch depth
		h = x - a - 24'((42'(bp) * $signed({24'h0, q})) >>> 16);
		b = bp + 24'((42'(h) * $signed({25'h0, f})) >>> 16);
		case (rs)
			RESP_LP: yy = a;
			RESP_HP: yy = h;
			RESP_BP: yy = b;
			default: yy = h + a;
		endcase
		return {yy, a, b};
	endfunction
	function automatic logic signed [15:0] sat16(input logic signed [49:0] v);
		if ((&v[49:15]) || !(|v[49:15]))
			return 16'(v);
		return v[49] ? 16'sh8000 : 16'sh7FFF;
	endfunction
endpackage

// ===== tsrf_core.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module tsrf_core
	import tsrf_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire logic               hsel,
	input  wire logic        [31:0] haddr,
	input  wire logic        [1:0]  htrans,
	input  wire logic               hwrite,
	input  wire logic        [2:0]  hsize,
	input  wire logic        [31:0] hwdata,
	input  wire logic               hreadyin,
	output logic             [31:0] hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               in_valid,
	input  wire logic signed [15:0] in_left,
	input  wire logic signed [15:0] in_right,
	input  wire logic        [7:0]  sys_tempo_bpm,
	input  wire logic signed [7:0]  mod_tempo_delta,
	output logic                    out_valid,
	output logic signed      [15:0] out_left,
	output logic signed      [15:0] out_right,
	output logic             [13:0] freq_left,
	output logic             [13:0] freq_right
);
	logic                     wr_pend_ff, rd_pend_ff, addr_ok_ff;
	logic                     hreadyout_ff, hresp_ff, take;
	logic [7:0]               addr_ff;
	logic [31:0]              hrdata_ff, rd_word;
	logic [5:0]               ctrl_ff, reson_ff;
	logic [7:0]               tempo_ff, teff_ff;
	logic [9:0]               beats_ff, den_ff;
	logic [6:0]               pulse_ff, smooth_ff, wet_ff;
	logic [13:0]              fmin_ff, fmax_ff;
	logic [11:0]              lph_ff, rph_ff;
	logic signed [7:0]        gain_db_ff;
	logic                     gain_off_ff;
	tsrf_div_t                div_st_ff;
	logic [4:0]               cnt_ff;
	logic [23:0]              quo_ff, inc_ff;
	logic [9:0]               rem_ff;
	logic [10:0]              r2;
	logic                     dbit;
	logic [31:0]              acc_ff;
	logic signed [9:0]        tsum;
	logic [17:0]              damp;
	logic [23:0]              glin;
	logic [31:0]              ph [2];
	logic [15:0]              u [2];
	logic [13:0]              nf [2], freq_ff [2];
	logic signed [23:0]       y [2], nlp [2], nbp [2], lp_ff [2], bp_ff [2];
	logic signed [24:0]       mx [2];
	logic signed [15:0]       o [2], out_ff [2];
	logic                     out_valid_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	assign take = hsel && htrans[1] && hreadyin;
	// Bus phases; a read adds one wait state so writes land first
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend_ff   <= 1'b0;
			rd_pend_ff   <= 1'b0;
			addr_ok_ff   <= 1'b0;
			addr_ff      <= 8'h00;
			hreadyout_ff <= 1'b1;
			hresp_ff     <= 1'b0;
			hrdata_ff    <= 32'h0000_0000;
		end else begin
			wr_pend_ff   <= take && hwrite && hsize == SIZE_WORD;
			rd_pend_ff   <= take && !hwrite;
			hreadyout_ff <= !(take && !hwrite);
			if (take) begin
				addr_ff    <= haddr[7:0];
				addr_ok_ff <= haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0;
			end
			if (rd_pend_ff)
				hrdata_ff <= addr_ok_ff ? rd_word : 32'h0000_0000;
		end
	end

	sequence s_rd_addr;
		hsel && htrans[1] && !hwrite && hreadyin;
	endsequence
	sequence s_rd_done;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (s_rd_addr |=> s_rd_done)
		else $error("read wait state wrong");

	// Register writes; all but CTRL clamped to legal ranges, CTRL stored as written
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_ff     <= RST_CTRL;
			tempo_ff    <= RST_TEMPO;
			beats_ff    <= RST_BEATS;
			pulse_ff    <= RST_PULSE;
			smooth_ff   <= 7'h00;
			fmin_ff     <= RST_FMIN;
			fmax_ff     <= RST_FMAX;
			reson_ff    <= 6'h00;
			lph_ff      <= 12'h000;
			rph_ff      <= 12'h000;
			wet_ff      <= RST_WET;
			gain_db_ff  <= 8'sh00;
			gain_off_ff <= 1'b0;
		end else if (wr_pend_ff && addr_ok_ff) begin
			case (addr_ff)
				OFS_CTRL:   ctrl_ff <= hwdata[5:0];
				// manual tempo range
				// Whole word clamped, so large values never wrap
				OFS_TEMPO:  tempo_ff <= 8'(clampu(hwdata, BPM_LO, BPM_HI));
				OFS_BEATS:  beats_ff <= 10'(clampu(hwdata, 32'h0, BEATS_HI));
				OFS_PULSE:  pulse_ff <= 7'(clampu(hwdata, 32'h0, PCT_HI));
				OFS_SMOOTH: smooth_ff <= 7'(clampu(hwdata, 32'h0, PCT_HI));
				OFS_FMIN:   fmin_ff <= 14'(clampu(hwdata, FREQ_LO, FREQ_HI));
				OFS_FMAX:   fmax_ff <= 14'(clampu(hwdata, FREQ_LO, FREQ_HI));
				OFS_RESON:  reson_ff <= 6'(clampu(hwdata, 32'h0, RESON_HI));
				OFS_LPHASE: lph_ff <= 12'(clampu(hwdata, 32'h0, PHASE_HI));
				OFS_RPHASE: rph_ff <= 12'(clampu(hwdata, 32'h0, PHASE_HI));
				OFS_WET:    wet_ff <= 7'(clampu(hwdata, 32'h0, PCT_HI));
				OFS_GAIN: begin
					gain_off_ff <= hwdata[GAIN_OFF_BIT];
					gain_db_ff  <= ($signed(hwdata[7:0]) < GAIN_LO) ? GAIN_LO :
						($signed(hwdata[7:0]) > GAIN_HI) ? GAIN_HI : $signed(hwdata[7:0]);
				end
				default: ;
			endcase
		end
	end

	a_fmin_range: assert property (fmin_ff >= 14'(FREQ_LO)
		&& fmin_ff <= 14'(FREQ_HI) && fmax_ff >= 14'(FREQ_LO)
		&& fmax_ff <= 14'(FREQ_HI))
		else $error("sweep limit out of range");

	// Read mux; unmapped words read zero
	always_comb begin
		case (addr_ff)
			OFS_CTRL:   rd_word = 32'(ctrl_ff);
			OFS_TEMPO:  rd_word = 32'(tempo_ff);
			OFS_BEATS:  rd_word = 32'(beats_ff);
			OFS_PULSE:  rd_word = 32'(pulse_ff);
			OFS_SMOOTH: rd_word = 32'(smooth_ff);
			OFS_FMIN:   rd_word = 32'(fmin_ff);
			OFS_FMAX:   rd_word = 32'(fmax_ff);
			OFS_RESON:  rd_word = 32'(reson_ff);
			OFS_LPHASE: rd_word = 32'(lph_ff);
			OFS_RPHASE: rd_word = 32'(rph_ff);
			OFS_WET:    rd_word = 32'(wet_ff);
			OFS_GAIN:   rd_word = {23'h0, gain_off_ff, gain_db_ff};
			OFS_METER:  rd_word = {2'h0, freq_ff[1], 2'h0, freq_ff[0]};
			OFS_PHASE:  rd_word = acc_ff;
			default:    rd_word = 32'h0000_0000;
		endcase
	end

	assign tsum = $signed({2'b00, tempo_ff}) + 10'(mod_tempo_delta);
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			teff_ff <= RST_TEMPO;
		else if (ctrl_ff[CTRL_SYS_BIT])
			teff_ff <= (sys_tempo_bpm == 8'h00) ? 8'h01 : sys_tempo_bpm;
		else
			teff_ff <= (tsum < 10'sh001) ? 8'h01 :
				(tsum > 10'sh0FF) ? 8'hFF : 8'(tsum);
	end

	a_sys_tempo: assert property (ctrl_ff[CTRL_SYS_BIT]
		&& sys_tempo_bpm != 8'h00 |=> teff_ff == $past(sys_tempo_bpm))
		else $error("system tempo not followed");

	// increment is tempo over beats, by serial division
	assign r2 = {rem_ff, quo_ff[23]};
	assign dbit = r2 >= {1'b0, den_ff};
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_st_ff <= DIV_LOAD;
			cnt_ff    <= 5'h00;
			quo_ff    <= 24'h000000;
			rem_ff    <= 10'h000;
			den_ff    <= 10'h000;
			inc_ff    <= 24'h000000;
		end else begin
			unique case (div_st_ff)
				DIV_LOAD: begin
					quo_ff    <= 24'(teff_ff) * 24'(INC_K);
					rem_ff    <= 10'h000;
					cnt_ff    <= 5'h00;
					den_ff    <= beats_ff;
					div_st_ff <= DIV_RUN;
				end
				DIV_RUN: begin
					quo_ff <= {quo_ff[22:0], dbit};
					rem_ff <= 10'(dbit ? r2 - {1'b0, den_ff} : r2);
					cnt_ff <= cnt_ff + 5'h01;
					if (cnt_ff == 5'h17) begin
						inc_ff    <= {quo_ff[22:0], dbit};
						div_st_ff <= DIV_LOAD;
					end
				end
				default: div_st_ff <= DIV_LOAD;
			endcase
		end
	end

	assign damp = 18'(db_lin(8'sh00 - $signed({2'b00, reson_ff})) << 1);
	assign glin = db_lin(gain_db_ff);
	// Per-channel datapath; coefficient uses last sample's frequency
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ph[c] = acc_ff + 32'(32'(c == 1 ? rph_ff : lph_ff) * PH_K);
			u[c] = wave(tsrf_wave_t'(ctrl_ff[CTRL_WAVE_LSB +: 3]),
				ph[c][31:16], pulse_ff, smooth_ff);
			nf[c] = fsweep(u[c], fmin_ff, fmax_ff);
			{y[c], nlp[c], nbp[c]} = svf(24'(c == 1 ? in_right : in_left),
				lp_ff[c], bp_ff[c], 17'(clampu((32'(freq_ff[c]) * FK_Q8)
				>> 8, 32'h0, 32'(F_MAX))), damp, tsrf_resp_t'(ctrl_ff[1:0]));
			mx[c] = mixq(25'(c == 1 ? in_right : in_left), 25'(y[c]),
				pct_q(wet_ff));
			o[c] = sat16((50'(mx[c]) * $signed({26'h0, glin})) >>> 16);
		end
	end

	// One step per audio sample; state headroom is 48 dB only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_ff       <= 32'h0000_0000;
			out_valid_ff <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				lp_ff[c]   <= 24'sh000000;
				bp_ff[c]   <= 24'sh000000;
				out_ff[c]  <= 16'sh0000;
				freq_ff[c] <= RST_FMIN;
			end
		end else begin
			out_valid_ff <= in_valid;
			if (in_valid) begin
				if (beats_ff != 10'h000)
					acc_ff <= acc_ff + 32'(inc_ff);
				for (int c = 0; c < 2; c++) begin
					lp_ff[c]   <= nlp[c];
					bp_ff[c]   <= nbp[c];
					freq_ff[c] <= nf[c];
					out_ff[c]  <= gain_off_ff ? 16'sh0000 : o[c];
				end
			end
		end
	end

	a_lfo_hold: assert property (in_valid && beats_ff == 10'h000
		|=> $stable(acc_ff))
		else $error("oscillator moved at zero period");
	a_acc_step: assert property (in_valid && beats_ff != 10'h000
		|=> acc_ff == $past(acc_ff) + 32'($past(inc_ff)))
		else $error("accumulator step wrong");
	a_freq_bound: assert property (freq_ff[0] >= 14'(FREQ_LO)
		&& freq_ff[0] <= 14'(FREQ_HI) && freq_ff[1] >= 14'(FREQ_LO)
		&& freq_ff[1] <= 14'(FREQ_HI))
		else $error("resonant frequency outside limits");
	a_gain_mute: assert property (in_valid && gain_off_ff
		|=> out_ff[0] == 16'sh0000 && out_ff[1] == 16'sh0000)
		else $error("output not muted");
	a_dry_pass: assert property (in_valid && wet_ff == 7'h00
		&& !gain_off_ff && gain_db_ff == 8'sh00
		|=> out_ff[0] == $past(in_left) && out_ff[1] == $past(in_right))
		else $error("dry path not exact");
	a_valid_lag: assert property (in_valid |=> out_valid ##1
		(out_valid == $past(in_valid)))
		else $error("output valid timing wrong");

	assign hrdata     = hrdata_ff;
	assign hreadyout  = hreadyout_ff;
	assign hresp      = hresp_ff;
	assign out_valid  = out_valid_ff;
	assign out_left   = out_ff[0];
	assign out_right  = out_ff[1];
	assign freq_left  = freq_ff[0];
	assign freq_right = freq_ff[1];
endmodule

// ===== tsrf_audio_partner.sv
`timescale 1ns/1ns
module tsrf_audio_partner (
	input  wire logic               core_clk,
	output logic                    in_valid,
	output logic signed      [15:0] in_left,
	output logic signed      [15:0] in_right,
	input  wire logic               out_valid,
	input  wire logic signed [15:0] out_left,
	input  wire logic signed [15:0] out_right
);
	logic signed [15:0] got_left;
	logic signed [15:0] got_right;
	int                 got_count;

	// Source idles with no pair offered
	initial begin
		in_valid = 1'b0;
		in_left = 16'h0000;
		in_right = 16'h0000;
		got_count = 0;
	end

	// Sink never stalls, so it takes every offered pair
	always @(posedge core_clk) begin
		if (out_valid === 1'b1) begin
			got_left <= out_left;
			got_right <= out_right;
			got_count <= got_count + 1;
		end
	end

	// headroom kept: callers feed small levels only
	task automatic send(input logic signed [15:0] l, r, input int gap);
		repeat (gap) @(posedge core_clk);
		in_valid <= 1'b1;
		in_left <= l;
		in_right <= r;
		@(posedge core_clk);
		// Released lines show the inverse, never stale data
		in_valid <= 1'b0;
		in_left <= ~l;
		in_right <= ~r;
	endtask
endmodule

// ===== tsrf_core_tb_top.sv
`timescale 1ns/1ns
module tsrf_core_tb_top
	import tsrf_pkg::*;
;
	logic               core_clk;
	logic               sys_rst;
	logic               hsel;
	logic        [31:0] haddr;
	logic        [1:0]  htrans;
	logic               hwrite;
	logic        [2:0]  hsize;
	logic        [31:0] hwdata;
	logic        [31:0] hrdata;
	logic               hreadyout;
	logic               hresp;
	wire logic          in_valid;
	wire logic   [15:0] in_left;
	wire logic   [15:0] in_right;
	logic        [7:0]  sys_tempo_bpm;
	logic signed [7:0]  mod_tempo_delta;
	logic               out_valid;
	logic        [15:0] out_left;
	logic        [15:0] out_right;
	logic        [13:0] freq_left;
	logic        [13:0] freq_right;
	int                 fails;
	int                 checks;

	tsrf_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hreadyin(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
		.in_left(in_left), .in_right(in_right),
		.sys_tempo_bpm(sys_tempo_bpm), .mod_tempo_delta(mod_tempo_delta),
		.out_valid(out_valid), .out_left(out_left), .out_right(out_right),
		.freq_left(freq_left), .freq_right(freq_right));

	tsrf_audio_partner audio (.core_clk(core_clk), .in_valid(in_valid),
		.in_left(in_left), .in_right(in_right), .out_valid(out_valid),
		.out_left(out_left), .out_right(out_right));

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	task automatic close_out;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Ready is sampled before the edge's own updates land
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 100) begin
				fails++;
				close_out;
			end
			@(posedge core_clk);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic wr,
		input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= sz;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, SIZE_WORD, d, x);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(a, 1'b0, SIZE_WORD, 32'h0, x);
		chk(x, e);
	endtask

	task automatic t_reset;
		chk({18'h0, freq_left}, 32'h0000_0008);
		rd_chk(OFS_CTRL, 32'h0000_0000);
		rd_chk(OFS_TEMPO, 32'h0000_0078);
		rd_chk(OFS_BEATS, 32'h0000_0018);
		rd_chk(OFS_PULSE, 32'h0000_0032);
		rd_chk(OFS_FMAX, 32'h0000_20B4);
		rd_chk(OFS_WET, 32'h0000_0064);
		rd_chk(8'h38, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
	endtask

	// Writes out of range clamp to the nearest legal value
	task automatic t_clamp;
		logic [7:0]  a[12] = '{OFS_FMIN, OFS_FMAX, OFS_TEMPO, OFS_TEMPO,
			OFS_BEATS, OFS_RESON, OFS_LPHASE, OFS_WET, OFS_SMOOTH,
			OFS_GAIN, OFS_FMIN, OFS_FMAX};
		logic [31:0] v[12] = '{32'h0, 32'hFFFF, 32'h0, 32'h12C, 32'h400,
			32'h64, 32'h1388, 32'hC8, 32'hFF, 32'h80, 32'h20B4, 32'h8};
		logic [31:0] e[12] = '{FREQ_LO, FREQ_HI, BPM_LO, BPM_HI, BEATS_HI,
			RESON_HI, PHASE_HI, PCT_HI, PCT_HI, 32'hB1, FREQ_HI, FREQ_LO};
		logic [31:0] x;
		for (int i = 0; i < 12; i++) begin
			wr(a[i], v[i]);
			rd_chk(a[i], e[i]);
		end
		// A byte write must leave the register alone
		bus(OFS_WET, 1'b1, 3'h0, 32'h10, x);
		rd_chk(OFS_WET, PCT_HI);
	endtask

	// Every response and every waveform is accepted and streams
	task automatic t_modes;
		int n;
		for (int rs = 0; rs < 4; rs++) begin
			for (int wv = 0; wv < 5; wv++) begin
				n = audio.got_count;
				wr(OFS_CTRL, 32'(rs + (wv << CTRL_WAVE_LSB)));
				rd_chk(OFS_CTRL, 32'(rs + (wv << CTRL_WAVE_LSB)));
				audio.send(16'h0200, 16'hFE00, 0);
				// Sink count lands one edge after out_valid
				repeat (2) @(posedge core_clk);
				chk(32'(audio.got_count - n), 32'h1);
			end
		end
	endtask

	// Dry only at unity gain, then gain off
	task automatic t_stream;
		wr(OFS_WET, 32'h0);
		wr(OFS_GAIN, 32'h0);
		audio.send(16'h03E8, 16'hFC18, 0);
		#1;
		chk({31'h0, out_valid}, 32'h1);
		chk({out_right, out_left}, 32'hFC18_03E8);
		@(posedge core_clk);
		#1;
		chk({31'h0, out_valid}, 32'h0);
		chk({audio.got_right, audio.got_left}, 32'hFC18_03E8);
		wr(OFS_GAIN, 32'h0000_0100);
		audio.send(16'h03E8, 16'hFC18, 0);
		audio.send(16'h0100, 16'h0100, 1);
		#1;
		chk({out_right, out_left}, 32'h0);
	endtask

	// Equal limits pin the sweep; the meter mirrors the outputs
	task automatic t_sweep;
		wr(OFS_FMIN, 32'h3E8);
		wr(OFS_FMAX, 32'h3E8);
		audio.send(16'h0010, 16'h0010, 0);
		audio.send(16'h0010, 16'h0010, 3);
		// Frequencies settle after the taking edge
		@(posedge core_clk);
		chk(32'(freq_left >= 984 && freq_left <= 1016), 32'h1);
		chk(32'(freq_right >= 984 && freq_right <= 1016), 32'h1);
		rd_chk(OFS_METER, 32'h03E8_03E8);
	endtask

	task automatic step(output logic [31:0] d);
		logic [31:0] p0;
		logic [31:0] p1;
		repeat (60) @(posedge core_clk);
		audio.send(16'h0040, 16'h0040, 0);
		bus(OFS_PHASE, 1'b0, SIZE_WORD, 32'h0, p0);
		audio.send(16'h0040, 16'h0040, 0);
		bus(OFS_PHASE, 1'b0, SIZE_WORD, 32'h0, p1);
		d = p1 - p0;
	endtask

	task automatic t_tempo;
		logic [31:0] d[6];
		wr(OFS_BEATS, 32'h18);
		wr(OFS_CTRL, 32'h1 << CTRL_SYS_BIT);
		step(d[0]);
		mod_tempo_delta <= 8'sh3C;
		step(d[1]);
		chk(d[1], d[0]);
		chk(32'(d[0] != 0), 32'h1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_TEMPO, 32'h78);
		step(d[2]);
		mod_tempo_delta <= 8'sh00;
		step(d[3]);
		chk(32'(d[2] != d[3]), 32'h1);
		chk(d[3], 32'h78 * 32'(INC_K) / 32'h18);
		wr(OFS_BEATS, 32'h30);
		step(d[4]);
		chk(32'((d[3] >> 1) - d[4] + 4 <= 8), 32'h1);
		wr(OFS_BEATS, 32'h0);
		step(d[5]);
		chk(d[5], 32'h0);
	endtask

	// Hang guard, far beyond the fewer than one thousand cycles needed
	initial begin
		#(40 * 30000);
		fails++;
		close_out;
	end

	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = SIZE_WORD;
		hwdata = 32'h0;
		sys_tempo_bpm = 8'h78;
		mod_tempo_delta = 8'sh00;
		fails = 0;
		checks = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset;
		t_clamp;
		t_modes;
		t_stream;
		t_sweep;
		t_tempo;
		// Second reset mid-run restores defaults
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset;
		close_out;
	end
endmodule
